// >>> epp_cycle_sequencer_bench.sv
// self-checking bench for the parallel port cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module epp_cycle_sequencer_bench;
   import eppsq_pkg::*;
   localparam int TOUT = 40;
   logic clock_i = 1'b0, rst_i = 1'b1, ior_n = 1'b1, iow_n = 1'b1, sel = 1'b0, adr = 1'b0;
   logic m19 = 1'b0, fifo = 1'b0, port_direction_bit = 1'b0, fval = 1'b0, mute = 1'b0, glitch = 1'b0;
   logic [DATA_W-1:0] hd = '0, fd = '0, rdb = '0, hq, cq, cwire, d, q;
   logic hoe_n, rdy, coe_n, wr_n, ds_n, as_n, dir, stb_n, frdy, tout, wait_n, busy;
   logic cmd_q = 1'b1;
   logic [3:0] dly = 4'h0;
   logic [DATA_W+3:0] snap;
   int n_fail = 0, total_checks = 0, n_to = 0, stall = 0, n = 0;
   always #5 clock_i = ~clock_i;
   eppsq_top #(.TIMEOUT_CYC(TOUT)) DUT (
      .clock_i(clock_i), .rst_i(rst_i), .ior_n_i(ior_n), .iow_n_i(iow_n),
      .port_sel_i(sel), .addr_cycle_i(adr), .host_data_lines_i(hd),
      .host_data_lines_o(hq), .host_data_lines_oe_n_o(hoe_n), .iochrdy_o(rdy),
      .mode_19_i(m19), .fifo_mode_i(fifo), .port_direction_bit_i(port_direction_bit),
      .wait_n_i(wait_n), .busy_i(busy), .cable_data_lines_i(cwire),
      .cable_data_lines_o(cq), .cable_data_lines_oe_n_o(coe_n), .write_n_o(wr_n),
      .data_strobe_n_o(ds_n), .addr_strobe_n_o(as_n), .dir_o(dir), .strobe_n_o(stb_n),
      .fifo_data_i(fd), .fifo_valid_i(fval), .fifo_ready_o(frdy), .timeout_o(tout)
   );
   eppsq_periph_model peer (
      .clock_i(clock_i), .mode_19_i(m19), .mute_i(mute), .glitch_i(glitch),
      .dly_i(dly), .rd_byte_i(rdb), .cmd_n_i(ds_n & as_n), .strobe_n_i(stb_n),
      .dev_data_i(cq), .dev_oe_n_i(coe_n), .wait_n_o(wait_n), .busy_o(busy),
      .cable_o(cwire)
   );
   // pins during the first cycle of each command strobe
   always @(posedge clock_i)
   begin
      cmd_q <= ds_n & as_n;
      if (cmd_q === 1'b1 && (ds_n & as_n) === 1'b0)
         snap <= {cwire, wr_n, dir, coe_n, as_n};
      if (tout === 1'b1)
         n_to <= n_to + 1;
   end
   task automatic chk1(input string w, input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s exp %b got %b", w, e, g);
      end
   endtask : chk1
   task automatic chk8(input string w, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", w, e, g);
      end
   endtask : chk8
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic cyc(input logic wr, input logic a, input logic [DATA_W-1:0] b);
      int k;
      k = 0;
      snap = 'x;
      @(posedge clock_i);
      sel <= 1'b1;
      adr <= a;
      hd <= b;
      port_direction_bit <= !wr;
      @(posedge clock_i);
      iow_n <= !wr;
      ior_n <= wr;
      do @(negedge clock_i); while (rdy !== 1'b0 && ++k < 8);
      chk1("stall", 1'b0, rdy);
      if (!m19 && !wr) chk1("cmd_17", 1'b0, ds_n & as_n);
      k = 0;
      do @(negedge clock_i); while (rdy !== 1'b1 && ++k < 300);
      stall = k;
      chk1("ready", 1'b1, rdy);
      if (m19) chk8("end_19", 8'h04, {5'h00, ds_n & as_n, dir, coe_n});
      @(negedge clock_i);
      q = hq;
      if (!wr) chk1("host_oe", 1'b0, hoe_n);
      @(posedge clock_i);
      iow_n <= 1'b1;
      ior_n <= 1'b1;
      sel <= 1'b0;
      repeat (8) @(negedge clock_i);
      chk1("wr_idle", 1'b1, wr_n);
      chk1("cmd_idle", 1'b1, ds_n & as_n);
   endtask : cyc
   initial
   begin
      #(20000 * 10);
      n_fail++;
      summarize();
   end
   initial
   begin
      void'($urandom(46003));
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(negedge clock_i);
      chk8("rst_pins", 8'h0D, {4'h0, rdy, wr_n, dir, coe_n});
      for (int i = 0; i < 16; i++)
      begin
         d = (i < 8) ? {DATA_W{i[2]}} : DATA_W'($urandom);
         @(posedge clock_i);
         m19 <= i[0];
         dly <= 4'($urandom_range(0, 7));
         rdb <= d;
         repeat (12) @(posedge clock_i);
         cyc(i[1], i[2], d);
         if (i[1]) chk8("cable", d, snap[DATA_W+3:4]);
         else chk8("host", d, q);
         chk8("pins", i[1] ? 8'h00 : 8'h07, {5'h00, snap[3:1]});
         chk1("which", !i[2], snap[0]);
      end
      @(posedge clock_i);
      m19 <= 1'b0;
      mute <= 1'b1;
      repeat (12) @(posedge clock_i);
      fork
         cyc(1'b1, 1'b0, 8'h5A);
         begin
            repeat (12) @(posedge clock_i);
            glitch <= 1'b1;
            repeat (4) @(posedge clock_i);
            glitch <= 1'b0;
         end
      join
      chk1("tout_len", 1'b1, stall >= TOUT - 2 && stall <= TOUT + 1);
      chk8("tout_cnt", 8'h01, 8'(n_to));
      @(posedge clock_i);
      mute <= 1'b0;
      fifo <= 1'b1;
      dly <= 4'h7;
      for (int k = 0; k < 2; k++)
      begin
         d = DATA_W'($urandom);
         n = 0;
         @(posedge clock_i);
         fd <= d;
         fval <= 1'b1;
         do @(negedge clock_i); while (frdy !== 1'b1 && ++n < 400);
         if (k > 0) chk1("gap", 1'b1, n >= F_GAP_CYC);
         @(posedge clock_i);
         fval <= 1'b0;
         n = 0;
         do @(negedge clock_i); while (stb_n !== 1'b0 && ++n < 400);
         chk8("fifo_data", d, cwire);
         n = 0;
         do @(negedge clock_i); while (stb_n === 1'b0 && ++n < 200);
         chk8("pulse", 8'(F_PULSE_CYC), 8'(n + 1));
      end
      summarize();
   end
endmodule : epp_cycle_sequencer_bench
`default_nettype wire

// >>> eppsq_periph_model.sv
// behavioural peripheral on the cable side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module eppsq_periph_model
   import eppsq_pkg::*;
(
   input wire logic clock_i, // device clock
   input wire logic mode_19_i, // 1 = 1.9 handshake
   input wire logic mute_i, // never answer
   input wire logic glitch_i, // short flip on wait
   input wire logic [3:0] dly_i, // answer delay, 0..7 cycles
   input wire logic [eppsq_pkg::DATA_W-1:0] rd_byte_i, // byte offered on reads
   input wire logic cmd_n_i, // both command strobes anded
   input wire logic strobe_n_i, // fifo strobe
   input wire logic [eppsq_pkg::DATA_W-1:0] dev_data_i, // cable byte from device
   input wire logic dev_oe_n_i, // low while device drives
   output logic wait_n_o, // wait line
   output logic busy_o, // busy line
   output logic [eppsq_pkg::DATA_W-1:0] cable_o // resolved cable level
);
   import eppsq_pkg::*;
   logic [16:0] cmd_sh = '0;
   logic [16:0] stb_sh = '0;
   logic [DATA_W-1:0] last = '0;
   logic talk;
   // wait follows the strobe a few cycles later, far inside the limit
   assign wait_n_o = glitch_i ^ (mute_i | (mode_19_i ~^ cmd_sh[{1'b0, dly_i} + 5'h01]));
   // byte stands a cycle before wait moves
   assign talk = !cmd_n_i && cmd_sh[dly_i] && dev_oe_n_i;
   // undriven cable shows a changing pattern
   assign cable_o = !dev_oe_n_i ? dev_data_i : (talk ? rd_byte_i : ~last);
   assign busy_o = stb_sh[dly_i];
   always @(posedge clock_i)
   begin
      cmd_sh <= {cmd_sh[15:0], !cmd_n_i};
      stb_sh <= {stb_sh[15:0], !strobe_n_i};
      last <= cable_o;
   end
endmodule : eppsq_periph_model
`default_nettype wire

// >>> eppsq_pkg.sv
// constants, state codes and pin-sample layout for the parallel port cycle sequencer
package eppsq_pkg;
   localparam int DATA_W = 8;
   localparam int CNT_W = 11;
   localparam int CLK_NS = 10;
   // wait line must sit still this long before it counts
   localparam int FILT_NS = 50;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   // handshake abandon window, low end of 10 to 12 us
   localparam int TOUT_US = 10;
   localparam int TOUT_CYC = TOUT_US * 1000 / CLK_NS;
   // forward fifo strobe pacing
   localparam int F_SETUP_NS = 600;
   localparam int F_PULSE_NS = 600;
   localparam int F_GAP_NS = 680;
   localparam int F_SETUP_CYC = (F_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int F_PULSE_CYC = (F_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int F_GAP_CYC = (F_GAP_NS + CLK_NS - 1) / CLK_NS;
   // bit positions of the synchronised pin vector
   localparam int SY_IOR = 0;
   localparam int SY_IOW = 1;
   localparam int SY_SEL = 2;
   localparam int SY_ADR = 3;
   localparam int SY_BUSY = 4;
   localparam int SY_HD = 5;
   localparam int SY_CD = 13;
   localparam int SY_W = 21;
   localparam logic [SY_W-1:0] SY_RST = 21'h000003;
   localparam logic [1:0] STRB_OFF = 2'h3;
   typedef enum logic [10:0] {
      ST_IDLE    = 11'h001,
      ST_W_ARM   = 11'h002,
      ST_W_GO    = 11'h004,
      ST_R_ARM   = 11'h008,
      ST_R_GO    = 11'h010,
      ST_CMD19   = 11'h020,
      ST_CMD17   = 11'h040,
      ST_DONE    = 11'h080,
      ST_F_SETUP = 11'h100,
      ST_F_PULSE = 11'h200,
      ST_F_GAP   = 11'h400
   } eppsq_state_e;
endpackage : eppsq_pkg

// >>> eppsq_top.sv
// Overview of operation
// - Wait line counts only after staying unchanged for at least 50 ns.
// - Write line stays high whenever no write cycle is running.
// - Outside fifo mode, host write strobe to the port pulls ready low, stalling the bus.
// - In 1.9 cycles ready returns only after wait is deasserted or the handshake timeout expires.
// - In 1.9 writes command strobe follows the peripheral asserting wait.
// - In 1.9 writes direction is low before write line falls.
// - In 1.9 cycles command strobe ends only when wait deasserts or the handshake timeout expires.
// - In 1.9 reads data is tri-stated before direction flips and strobe.
// - In 1.9 reads wait deassert returns direction low and redrives data.
// - In reads write line is high before command strobe asserts.
// - Read byte from the cable is passed to the host data lines.
// - In 1.7 cycles ready returns when the peripheral asserts wait.
// - In 1.7 reads command strobe follows host read with no wait check.
// - Fifo mode ignores acknowledge and paces each byte on busy only.
// - Fifo forward bytes come from dma near 500 kbyte per second.
`timescale 1ns/1ps
`default_nettype none
module eppsq_top
   import eppsq_pkg::*;
#(
   parameter int TIMEOUT_CYC = eppsq_pkg::TOUT_CYC
)(
   input wire logic clock_i,                                   // 100 MHz device clock
   input wire logic rst_i,                                     // async reset, high
   input wire logic ior_n_i,                                   // host read strobe pin
   input wire logic iow_n_i,                                   // host write strobe pin
   input wire logic port_sel_i,                                // host address hits port
   input wire logic addr_cycle_i,                              // 1 address, 0 data register
   input wire logic [eppsq_pkg::DATA_W-1:0] host_data_lines_i, // host data in
   output logic [eppsq_pkg::DATA_W-1:0] host_data_lines_o,     // host data out
   output logic host_data_lines_oe_n_o,                        // low while driving host
   output logic iochrdy_o,                                     // low stalls host cycle
   input wire logic mode_19_i,                                 // 1 selects 1.9 handshake
   input wire logic fifo_mode_i,                               // forward fifo mode
   input wire logic port_direction_bit_i,                      // software direction bit
   input wire logic wait_n_i,                                  // peripheral wait pin
   input wire logic busy_i,                                    // peripheral busy pin
   input wire logic [eppsq_pkg::DATA_W-1:0] cable_data_lines_i, // cable data in
   output logic [eppsq_pkg::DATA_W-1:0] cable_data_lines_o,    // cable data out
   output logic cable_data_lines_oe_n_o,                       // low while driving cable
   output logic write_n_o,                                     // cable write line
   output logic data_strobe_n_o,                               // data command strobe
   output logic addr_strobe_n_o,                               // address command strobe
   output logic dir_o,                                         // cable direction, 1 input
   output logic strobe_n_o,                                    // fifo forward strobe
   input wire logic [eppsq_pkg::DATA_W-1:0] fifo_data_i,       // dma byte
   input wire logic fifo_valid_i,                              // dma byte valid
   output logic fifo_ready_o,                                  // dma byte taken
   output logic timeout_o                                      // handshake abandoned
);
   typedef struct packed {
      eppsq_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [SY_W-1:0] sy1;
      logic [SY_W-1:0] sy2;
      logic rd;
      logic adr;
      logic iochrdy;
      logic write_n;
      logic [1:0] strb_n;
      logic dir;
      logic pd_oe_n;
      logic [DATA_W-1:0] pd;
      logic [DATA_W-1:0] sd;
      logic sd_oe_n;
      logic strobe_n;
      logic fifo_rdy;
      logic tout;
   } eppsq_state_s;

   eppsq_state_s q, n;
   eppsq_wait_if wif ();
   logic wlv, ior_n, iow_n, sel, busy, stall;
   logic [DATA_W-1:0] hd, cd;

   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << CNT_W)) begin : g_chk
      $error("timeout count out of range");
   end

   eppsq_wait_filter u_filt (
      .clock_i  (clock_i),
      .rst_i    (rst_i),
      .wait_n_i (wait_n_i),
      .flt      (wif.src)
   );

   assign wlv = wif.settled_n;
   assign ior_n = q.sy2[SY_IOR];
   assign iow_n = q.sy2[SY_IOW];
   assign sel = q.sy2[SY_SEL];
   assign busy = q.sy2[SY_BUSY];
   assign hd = q.sy2[SY_HD +: DATA_W];
   assign cd = q.sy2[SY_CD +: DATA_W];
   assign stall = !q.iochrdy && (q.st != ST_DONE) && (q.st != ST_IDLE);

   // {address strobe, data strobe}, active low
   function automatic logic [1:0] strb_on(input logic adr);
      return adr ? 2'h1 : 2'h2;
   endfunction : strb_on

   always_comb
   begin
      n = q;
      n.sy1 = {cable_data_lines_i, host_data_lines_i, busy_i, addr_cycle_i, port_sel_i, iow_n_i, ior_n_i};
      n.sy2 = q.sy1;
      n.tout = 1'b0;
      n.fifo_rdy = 1'b0;
      n.cnt = q.cnt + 1'b1;
      case (q.st)
         ST_IDLE:
         begin
            n.cnt = '0;
            n.iochrdy = 1'b1;
            n.write_n = 1'b1;
            n.strb_n = STRB_OFF;
            n.sd_oe_n = 1'b1;
            n.dir = port_direction_bit_i;
            n.pd_oe_n = port_direction_bit_i;
            if (fifo_mode_i)
            begin
               // acknowledge is never looked at here
               n.fifo_rdy = !busy && !q.fifo_rdy;
               if (q.fifo_rdy && fifo_valid_i && !busy)
               begin
                  n.pd = fifo_data_i;
                  n.pd_oe_n = 1'b0;
                  n.dir = 1'b0;
                  n.st = ST_F_SETUP;
               end
            end
            else if (sel && !iow_n)
            begin
               n.iochrdy = 1'b0;
               n.rd = 1'b0;
               n.adr = q.sy2[SY_ADR];
               n.pd = hd;
               n.pd_oe_n = 1'b0;
               n.dir = 1'b0;
               if (mode_19_i)
               begin
                  n.st = ST_W_ARM;
               end
               else
               begin
                  n.write_n = 1'b0;
                  n.st = ST_W_GO;
               end
            end
            else if (sel && !ior_n)
            begin
               n.iochrdy = 1'b0;
               n.rd = 1'b1;
               n.adr = q.sy2[SY_ADR];
               n.pd_oe_n = 1'b1;
               if (mode_19_i)
               begin
                  n.st = ST_R_ARM;
               end
               else
               begin
                  n.dir = 1'b1;
                  n.strb_n = strb_on(q.sy2[SY_ADR]);
                  n.st = ST_CMD17;
               end
            end
         end
         ST_W_ARM:
         begin
            if (!wlv)
            begin
               n.write_n = 1'b0;
               n.st = ST_W_GO;
            end
         end
         ST_W_GO:
         begin
            n.strb_n = strb_on(q.adr);
            n.st = mode_19_i ? ST_CMD19 : ST_CMD17;
         end
         ST_R_ARM:
         begin
            if (!wlv)
            begin
               n.dir = 1'b1;
               n.st = ST_R_GO;
            end
         end
         ST_R_GO:
         begin
            n.strb_n = strb_on(q.adr);
            n.st = ST_CMD19;
         end
         ST_CMD19:
         begin
            if (wlv)
            begin
               n.strb_n = STRB_OFF;
               n.iochrdy = 1'b1;
               n.st = ST_DONE;
               if (q.rd)
               begin
                  n.sd = cd;
                  n.dir = 1'b0;
                  n.pd_oe_n = 1'b0;
               end
            end
         end
         ST_CMD17:
         begin
            if (!wlv)
            begin
               n.iochrdy = 1'b1;
               n.st = ST_DONE;
               if (q.rd)
               begin
                  n.sd = cd;
               end
            end
         end
         ST_DONE:
         begin
            n.cnt = '0;
            n.sd_oe_n = !(q.rd && !ior_n);
            if (ior_n && iow_n)
            begin
               n.strb_n = STRB_OFF;
               n.write_n = 1'b1;
               n.sd_oe_n = 1'b1;
               n.st = ST_IDLE;
            end
         end
         ST_F_SETUP:
         begin
            if (q.cnt == CNT_W'(F_SETUP_CYC - 1))
            begin
               n.cnt = '0;
               n.strobe_n = 1'b0;
               n.st = ST_F_PULSE;
            end
         end
         ST_F_PULSE:
         begin
            if (q.cnt == CNT_W'(F_PULSE_CYC - 1))
            begin
               n.cnt = '0;
               n.strobe_n = 1'b1;
               n.st = ST_F_GAP;
            end
         end
         ST_F_GAP:
         begin
            // only busy paces the next byte
            if (busy)
            begin
               n.cnt = '0;
            end
            else if (q.cnt == CNT_W'(F_GAP_CYC - 1))
            begin
               n.cnt = '0;
               n.st = ST_IDLE;
            end
         end
         default:
         begin
            n.st = ST_IDLE;
         end
      endcase
      // peripheral never finished the handshake
      if (stall && q.cnt == CNT_W'(TIMEOUT_CYC - 1))
      begin
         n.tout = 1'b1;
         n.iochrdy = 1'b1;
         n.strb_n = STRB_OFF;
         n.st = ST_DONE;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '{st: ST_IDLE, cnt: '0, sy1: SY_RST, sy2: SY_RST, rd: 1'b0, adr: 1'b0,
                iochrdy: 1'b1, write_n: 1'b1, strb_n: STRB_OFF, dir: 1'b0, pd_oe_n: 1'b1,
                pd: '0, sd: '0, sd_oe_n: 1'b1, strobe_n: 1'b1, fifo_rdy: 1'b0, tout: 1'b0};
      end
      else
      begin
         q <= n;
      end
   end

   assign host_data_lines_o = q.sd;
   assign host_data_lines_oe_n_o = q.sd_oe_n;
   assign iochrdy_o = q.iochrdy;
   assign cable_data_lines_o = q.pd;
   assign cable_data_lines_oe_n_o = q.pd_oe_n;
   assign write_n_o = q.write_n;
   assign addr_strobe_n_o = q.strb_n[1];
   assign data_strobe_n_o = q.strb_n[0];
   assign dir_o = q.dir;
   assign strobe_n_o = q.strobe_n;
   assign fifo_ready_o = q.fifo_rdy;
   assign timeout_o = q.tout;

   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   AST_WRITE_IDLE_HIGH: assert property ((q.st == ST_IDLE) |-> q.write_n)
      else $error("write line low while idle");
   AST_STALL_ON_WRITE: assert property (
      (q.st == ST_IDLE && !fifo_mode_i && sel && !iow_n) |=> (!q.iochrdy && q.st != ST_IDLE))
      else $error("host write not stalled");
   AST_RDY19_AFTER_WAIT: assert property (
      ($rose(q.iochrdy) && mode_19_i && q.st == ST_DONE) |-> ($past(wlv) || q.tout))
      else $error("ready released before wait deasserted");
   AST_STB_AFTER_WAIT: assert property (
      ($fell(q.strb_n[0] & q.strb_n[1]) && !q.rd && mode_19_i) |-> (!$past(wlv, 2) && !q.write_n))
      else $error("write strobe before wait asserted");
   AST_DIR_BEFORE_WRITE: assert property ($fell(q.write_n) |-> (!q.dir && !$past(q.dir)))
      else $error("write line fell with direction high");
   AST_STB_END_19: assert property (
      ($rose(q.strb_n[0] & q.strb_n[1]) && mode_19_i) |-> ($past(wlv) || q.tout))
      else $error("command strobe ended without wait");
   AST_READ_TRI: assert property (
      ($fell(q.strb_n[0] & q.strb_n[1]) && q.rd) |-> (q.pd_oe_n && $past(q.pd_oe_n) && q.dir))
      else $error("cable driven at read strobe");
   AST_READ_REDRIVE: assert property (
      ($rose(q.strb_n[0] & q.strb_n[1]) && q.rd && mode_19_i && !q.tout) |-> (!q.dir && !q.pd_oe_n))
      else $error("cable not redriven after read");
   AST_NWRITE_READ: assert property (($fell(q.strb_n[0] & q.strb_n[1]) && q.rd) |-> q.write_n)
      else $error("write line low at read strobe");
   AST_READ_DATA: assert property (
      ($rose(q.iochrdy) && q.rd && !q.tout) |-> (q.sd == $past(cd)))
      else $error("read byte not captured");
   AST_RDY17_ON_WAIT: assert property (
      ($rose(q.iochrdy) && !mode_19_i) |-> (!$past(wlv) || q.tout))
      else $error("1.7 ready released without wait");
   AST_STB_END_17: assert property (
      (q.st == ST_DONE && !mode_19_i && ior_n && iow_n) |=> (q.strb_n == STRB_OFF && q.write_n))
      else $error("1.7 strobe kept after host strobe");
   AST_FIFO_ON_BUSY: assert property (
      (q.st == ST_F_SETUP && $past(q.st) == ST_IDLE) |-> !$past(busy))
      else $error("fifo byte started while busy");
   AST_TIMEOUT_BOUND: assert property (!q.iochrdy |-> (q.cnt < CNT_W'(TIMEOUT_CYC)))
      else $error("stall longer than timeout");

   COV_WRITE_19: cover property ($rose(q.iochrdy) && !q.rd && mode_19_i && !q.tout);
   COV_READ_17: cover property ($rose(q.iochrdy) && q.rd && !mode_19_i && !q.tout);
   COV_TIMEOUT: cover property (q.tout);
   COV_FIFO_BYTE: cover property ($rose(q.strobe_n));
endmodule : eppsq_top
`default_nettype wire

// >>> eppsq_wait_filter.sv
// synchroniser and deglitch filter for the peripheral wait line
`timescale 1ns/1ps
`default_nettype none
module eppsq_wait_filter
   import eppsq_pkg::*;
#(
   parameter int STABLE_CYC = eppsq_pkg::FILT_CYC
)(
   input wire logic clock_i,     // device clock
   input wire logic rst_i,       // async reset, high
   input wire logic wait_n_i,    // raw wait pin, low active
   eppsq_wait_if.src flt         // settled level out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic [3:0] cnt;
   } eppsq_flt_s;

   eppsq_flt_s q, n;

   if (STABLE_CYC < 1 || STABLE_CYC > 15) begin : g_chk
      $error("filter length out of range");
   end

   always_comb
   begin
      n = q;
      n.s1 = wait_n_i;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // restart whenever the line moves, accept after a quiet stretch
      if (q.s2 != q.s3)
      begin
         n.cnt = 4'h0;
      end
      else if (q.s2 != q.lvl)
      begin
         if (q.cnt == 4'(STABLE_CYC - 1))
         begin
            n.lvl = q.s2;
            n.cnt = 4'h0;
         end
         else
         begin
            n.cnt = q.cnt + 4'h1;
         end
      end
      else
      begin
         n.cnt = 4'h0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, cnt: 4'h0};
      end
      else
      begin
         q <= n;
      end
   end

   assign flt.settled_n = q.lvl;

   AST_FILT_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
      $changed(q.lvl) |-> ($past(q.s2, 1) == q.lvl && $past(q.s2, STABLE_CYC) == q.lvl))
      else $error("wait level accepted before settling");
endmodule : eppsq_wait_filter
`default_nettype wire

// >>> eppsq_wait_if.sv
// carries the settled wait level from the filter to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface eppsq_wait_if;
   logic settled_n;
   modport src (output settled_n);
   modport dst (input settled_n);
endinterface : eppsq_wait_if
`default_nettype wire
